// ### core/olcr_defines.svh
// register offsets, field positions and reset values of the line interface register bank
`ifndef OLCR_DEFINES_SVH
`define OLCR_DEFINES_SVH

// =====================================================================
// primary bank offsets
`define OLCR_OFS_LOS_STATUS 5'h04
`define OLCR_OFS_AUTO_ALL_ONES 5'h0e
`define OLCR_OFS_GLOBAL_CFG 5'h0f
`define OLCR_OFS_TMPL_INDEX 5'h10
`define OLCR_OFS_TMPL_SELECT 5'h11
`define OLCR_OFS_DRIVER_OFF 5'h12
`define OLCR_OFS_AIS_STATUS 5'h13
`define OLCR_OFS_AIS_MASK 5'h14
`define OLCR_OFS_AIS_EVENT 5'h15
`define OLCR_OFS_BANK_PTR 5'h1f

// =====================================================================
// expanded bank offsets
`define OLCR_OFS_SINGLE_RAIL 5'h00
`define OLCR_OFS_CLK_REC_DIS 5'h02

// =====================================================================
// bank pointer codes
`define OLCR_BANK_PRIMARY 8'h00
`define OLCR_BANK_EXPANDED 8'haa

// =====================================================================
// global configuration fields
`define OLCR_GCF_AIS_INSERT 6
`define OLCR_GCF_SHORT_DIS 5
`define OLCR_GCF_LINE_CODE 4
`define OLCR_GCF_JA_DEPTH 3
`define OLCR_GCF_JA_BW 2
`define OLCR_GCF_JA_PLACE_HI 1
`define OLCR_GCF_JA_PLACE_LO 0
`define OLCR_JA_TRANSMIT 2'b01
`define OLCR_JA_RECEIVE 2'b11

// =====================================================================
// reset values
`define OLCR_RST_BYTE 8'h00
`define OLCR_RST_TMPL 3'h0

`endif

// ### core/olcr_pkg.sv
// shared types of the line interface register bank
package olcr_pkg;

  // =====================================================================
  // sizes and storage types
  localparam int OLCR_CHANNELS = 8;
  typedef logic [7:0] olcr_byte_t;
  typedef logic [OLCR_CHANNELS-1:0][7:0] olcr_tmpl_t;

  // which bank the pointer currently maps
  typedef enum logic {
    OLCR_PRIMARY,
    OLCR_EXPANDED
  } olcr_bank_e;

endpackage

// ### core/olcr_sync.sv
// two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ps

module olcr_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } olcr_sync_s;

  olcr_sync_s state_reg;
  olcr_sync_s state_next;

  // =====================================================================
  // stage1 feeds only stage2, so no logic sees a metastable value
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = async;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign synced = state_reg.stage2;

endmodule // olcr_sync

// ### core/olcr_alarm_chan.sv
// per-channel alarm status tracker with masked change latch
`timescale 1ns/1ps

module olcr_alarm_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic alarmLevel,
  input wire logic maskAllow,
  input wire logic statusRead,
  output logic alarmStatus,
  output logic alarmEvent
);

  typedef struct packed {
    logic status;
    logic event_;
  } olcr_chan_s;

  olcr_chan_s state_reg;
  olcr_chan_s state_next;
  logic changed;

  // =====================================================================
  // change seen against the held status; a change in the clearing cycle wins
  always_comb
  begin
    changed = alarmLevel != state_reg.status;
    state_next = state_reg;
    state_next.status = alarmLevel;
    if (statusRead)
    begin
      state_next.event_ = 1'b0;
    end
    if (changed && maskAllow)
    begin
      state_next.event_ = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign alarmStatus = state_reg.status;
  assign alarmEvent = state_reg.event_;

endmodule // olcr_alarm_chan

// ### core/olcr_regs.sv
// control and alarm register bank of an octal line interface
//
// Contract
// - channels with auto all-ones set send all ones while in loss of signal.
// - global insert bit 6 enables alarm insertion toward system side on loss of signal.
// - global bit 5 zero turns short protection on from the first clock after reset, one disables it.
// - global bit 4 selects B8ZS/HDB3 coding at zero, AMI at one.
// - global bit 3 selects attenuator depth 32 at zero, 64 at one.
// - global bit 2 selects low or high jitter transfer corner.
// - placement 01 puts attenuator in transmit path, 11 receive, else unused.
// - template index low bits pick which channel the template register accesses.
// - three-bit template code picks E1 or one of five T1 lengths.
// - output disable bit one puts channel driver in high impedance.
// - alarm status register bit reads one while channel detects alarm.
// - alarm mask bit one allows that channel's event, zero blocks it.
// - alarm event latches on status change when allowed, clears after status read.
// - bank pointer AAH maps expanded bank, 00H maps primary bank.
// - bank pointer points to primary bank after power up.
// - single rail force one with recovery enabled forces single rail, else pin decides.
// - clock recovery disable bit zero enables recovery, one disables it.
// - loss of signal status is readable and drives all-ones and insertion.
`timescale 1ns/1ps
`include "olcr_defines.svh"

module olcr_regs
  import olcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // host register port, same clock domain
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // line status from the receivers, asynchronous
  input wire logic [7:0] losIn,
  input wire logic [7:0] aisIn,
  input wire logic [7:0] railSelectPin,
  // controls toward the datapath
  output logic [7:0] allOnesTransmit,
  output logic [7:0] aisInsert,
  output logic shortProtectEnable,
  output logic amiSelect,
  output logic attenuatorDepth64,
  output logic attenuatorBandwidthHigh,
  output logic attenuatorInTransmit,
  output logic attenuatorInReceive,
  output logic [23:0] templateCode,
  output logic [7:0] driverHighZ,
  output logic [7:0] singleRail,
  output logic [7:0] clockRecoveryOff,
  output logic [7:0] aisEventFlags,
  output logic bankExpanded
);

  // =====================================================================
  // state
  typedef struct packed {
    olcr_byte_t autoAllOnes;
    olcr_byte_t globalCfg;
    olcr_byte_t tmplIndex;
    olcr_tmpl_t tmplSel;
    olcr_byte_t driverOff;
    olcr_byte_t aisMask;
    olcr_byte_t bankPtr;
    olcr_byte_t singleRailForce;
    olcr_byte_t clkRecDisable;
    olcr_byte_t rdData;
    olcr_byte_t allOnes;
    olcr_byte_t aisIns;
    logic shortProtEn;
    logic ami;
    logic depth64;
    logic bwHigh;
    logic jaTx;
    logic jaRx;
    logic [23:0] tmplOut;
    olcr_byte_t highZ;
    olcr_byte_t single;
    olcr_byte_t crOff;
    logic expanded;
  } olcr_regs_s;

  olcr_regs_s state_reg;
  olcr_regs_s state_next;

  logic [7:0] losSync;
  logic [7:0] aisSync;
  logic [7:0] railSync;
  logic [7:0] aisStatus;
  logic [7:0] aisEvent;
  logic aisStatusRead;
  olcr_bank_e bank;
  logic [2:0] tmplCh;
  logic [7:0] rdMux;

  // =====================================================================
  // pin crossings: every external level passes two flip-flops
  // this costs two cycles of latency on every line status, traded for safe sampling
  olcr_sync #(
    .W(8)
  ) u_los_sync (
    .clk(clk),
    .rst(rst),
    .async(losIn),
    .synced(losSync)
  );

  olcr_sync #(
    .W(8)
  ) u_ais_sync (
    .clk(clk),
    .rst(rst),
    .async(aisIn),
    .synced(aisSync)
  );

  olcr_sync #(
    .W(8)
  ) u_rail_sync (
    .clk(clk),
    .rst(rst),
    .async(railSelectPin),
    .synced(railSync)
  );

  // =====================================================================
  // bank decode and indirect template channel
  // pointer values other than AAH are stored but keep the primary bank mapped
  always_comb
  begin
    if (state_reg.bankPtr == `OLCR_BANK_EXPANDED)
    begin
      bank = OLCR_EXPANDED;
    end
    else
    begin
      bank = OLCR_PRIMARY;
    end
    tmplCh = state_reg.tmplIndex[2:0];
  end

  // reading the alarm status register clears the latched events
  assign aisStatusRead = regRead && (bank == OLCR_PRIMARY)
    && (regAddr == `OLCR_OFS_AIS_STATUS);

  // =====================================================================
  // per-channel alarm trackers
  // each keeps a status copy that doubles as the previous level for change detection
  for (genvar ch = 0; ch < OLCR_CHANNELS; ch++)
  begin : g_alarm
    olcr_alarm_chan u_chan (
      .clk(clk),
      .rst(rst),
      .alarmLevel(aisSync[ch]),
      .maskAllow(state_reg.aisMask[ch]),
      .statusRead(aisStatusRead),
      .alarmStatus(aisStatus[ch]),
      .alarmEvent(aisEvent[ch])
    );
  end

  // =====================================================================
  // read multiplexer; unmapped offsets read zero
  // the expanded bank maps only single rail force, clock recovery disable and the bank pointer
  always_comb
  begin
    rdMux = 8'h00;
    if (regAddr == `OLCR_OFS_BANK_PTR)
    begin
      rdMux = state_reg.bankPtr; // pointer visible in either bank
    end
    else if (bank == OLCR_EXPANDED)
    begin
      case (regAddr)
        `OLCR_OFS_SINGLE_RAIL: rdMux = state_reg.singleRailForce;
        `OLCR_OFS_CLK_REC_DIS: rdMux = state_reg.clkRecDisable;
        default: rdMux = 8'h00;
      endcase
    end
    else
    begin
      case (regAddr)
        `OLCR_OFS_LOS_STATUS: rdMux = losSync;
        `OLCR_OFS_AUTO_ALL_ONES: rdMux = state_reg.autoAllOnes;
        `OLCR_OFS_GLOBAL_CFG: rdMux = state_reg.globalCfg;
        `OLCR_OFS_TMPL_INDEX: rdMux = state_reg.tmplIndex;
        `OLCR_OFS_TMPL_SELECT: rdMux = state_reg.tmplSel[tmplCh];
        `OLCR_OFS_DRIVER_OFF: rdMux = state_reg.driverOff;
        `OLCR_OFS_AIS_STATUS: rdMux = aisStatus;
        `OLCR_OFS_AIS_MASK: rdMux = state_reg.aisMask;
        `OLCR_OFS_AIS_EVENT: rdMux = aisEvent;
        default: rdMux = 8'h00;
      endcase
    end
  end

  // =====================================================================
  // register writes, read data capture and registered control outputs
  always_comb
  begin
    state_next = state_reg;
    // read data is captured on the strobe edge, so a same-cycle write is not seen
    if (regRead)
    begin
      state_next.rdData = rdMux;
    end
    // writes to read-only or unmapped offsets fall to the default and change nothing
    if (regWrite)
    begin
      if (regAddr == `OLCR_OFS_BANK_PTR)
      begin
        state_next.bankPtr = regWdata;
      end
      else if (bank == OLCR_EXPANDED)
      begin
        case (regAddr)
          `OLCR_OFS_SINGLE_RAIL: state_next.singleRailForce = regWdata;
          `OLCR_OFS_CLK_REC_DIS: state_next.clkRecDisable = regWdata;
          default: state_next.bankPtr = state_reg.bankPtr;
        endcase
      end
      else
      begin
        case (regAddr)
          `OLCR_OFS_AUTO_ALL_ONES: state_next.autoAllOnes = regWdata;
          `OLCR_OFS_GLOBAL_CFG: state_next.globalCfg = regWdata;
          `OLCR_OFS_TMPL_INDEX: state_next.tmplIndex = regWdata;
          `OLCR_OFS_TMPL_SELECT: state_next.tmplSel[tmplCh] = regWdata;
          `OLCR_OFS_DRIVER_OFF: state_next.driverOff = regWdata;
          `OLCR_OFS_AIS_MASK: state_next.aisMask = regWdata;
          default: state_next.bankPtr = state_reg.bankPtr; // read-only or unmapped
        endcase
      end
    end

    // loss of signal drives the all-ones and alarm insertion requests
    state_next.allOnes = state_reg.autoAllOnes & losSync;
    state_next.aisIns = {8{state_reg.globalCfg[`OLCR_GCF_AIS_INSERT]}} & losSync;

    // global datapath selections, one cycle behind the register
    state_next.shortProtEn = ~state_reg.globalCfg[`OLCR_GCF_SHORT_DIS];
    state_next.ami = state_reg.globalCfg[`OLCR_GCF_LINE_CODE];
    state_next.depth64 = state_reg.globalCfg[`OLCR_GCF_JA_DEPTH];
    state_next.bwHigh = state_reg.globalCfg[`OLCR_GCF_JA_BW];
    state_next.jaTx = state_reg.globalCfg[`OLCR_GCF_JA_PLACE_HI:`OLCR_GCF_JA_PLACE_LO]
      == `OLCR_JA_TRANSMIT;
    state_next.jaRx = state_reg.globalCfg[`OLCR_GCF_JA_PLACE_HI:`OLCR_GCF_JA_PLACE_LO]
      == `OLCR_JA_RECEIVE;

    // template codes: reserved code values are passed on unchanged
    for (int ch = 0; ch < OLCR_CHANNELS; ch++)
    begin
      state_next.tmplOut[ch*3 +: 3] = state_reg.tmplSel[ch][2:0];
    end

    state_next.highZ = state_reg.driverOff;
    // forcing needs clock recovery enabled; otherwise the pin keeps control
    state_next.single = (state_reg.singleRailForce & ~state_reg.clkRecDisable)
      | (~(state_reg.singleRailForce & ~state_reg.clkRecDisable) & railSync);
    state_next.crOff = state_reg.clkRecDisable;
    state_next.expanded = bank == OLCR_EXPANDED;
  end

  // all fields reset to zero, which also points at the primary bank
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // outputs straight from flip-flops
  // host read data, held from one read strobe to the next
  assign regRdata = state_reg.rdData;

  // line-side requests that follow loss of signal
  assign allOnesTransmit = state_reg.allOnes;
  assign aisInsert = state_reg.aisIns;

  // global coding, protection and attenuator selections
  assign shortProtectEnable = state_reg.shortProtEn;
  assign amiSelect = state_reg.ami;
  assign attenuatorDepth64 = state_reg.depth64;
  assign attenuatorBandwidthHigh = state_reg.bwHigh;
  assign attenuatorInTransmit = state_reg.jaTx;
  assign attenuatorInReceive = state_reg.jaRx;

  // per-channel transmit and receive settings
  assign templateCode = state_reg.tmplOut;
  assign driverHighZ = state_reg.highZ;
  assign singleRail = state_reg.single;
  assign clockRecoveryOff = state_reg.crOff;

  // alarm events come from the tracker flip-flops, not from this struct
  assign aisEventFlags = aisEvent;
  assign bankExpanded = state_reg.expanded;

endmodule // olcr_regs

// ### verif/olcr_regs_properties.sv
// checker of the line interface register bank, port level relations
`timescale 1ns/1ps

module olcr_regs_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] losIn,
  input wire logic [7:0] railSelectPin,
  input wire logic [7:0] allOnesTransmit,
  input wire logic [7:0] aisInsert,
  input wire logic shortProtectEnable,
  input wire logic amiSelect,
  input wire logic attenuatorDepth64,
  input wire logic attenuatorBandwidthHigh,
  input wire logic attenuatorInTransmit,
  input wire logic attenuatorInReceive,
  input wire logic [7:0] driverHighZ,
  input wire logic [7:0] singleRail,
  input wire logic [7:0] clockRecoveryOff,
  input wire logic [7:0] aisEventFlags,
  input wire logic bankExpanded
);
  // =====================================================================
  // one clock domain, so clocking and disable are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // bank the host has mapped, followed from pointer writes; the registered
  // bankExpanded output lags a cycle and would misjudge a back-to-back access
  logic bankNow;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bankNow <= 1'b0;
    end
    else if (regWrite && regAddr == 5'h1f)
    begin
      bankNow <= regWdata == 8'haa;
    end
  end

  // a global write shows on the controls two samples later
  property p_gcf_code;
    regWrite && regAddr == 5'h0f && !bankNow |-> ##2
      shortProtectEnable == !$past(regWdata[5], 2) && amiSelect == $past(regWdata[4], 2);
  endproperty
  a_gcf_code: assert property (p_gcf_code)
    else $error("coding or protection control wrong");
  property p_gcf_ja;
    regWrite && regAddr == 5'h0f && !bankNow |-> ##2
      attenuatorDepth64 == $past(regWdata[3], 2) && attenuatorBandwidthHigh == $past(regWdata[2], 2);
  endproperty
  a_gcf_ja: assert property (p_gcf_ja)
    else $error("attenuator depth or bandwidth wrong");
  property p_gcf_place;
    regWrite && regAddr == 5'h0f && !bankNow |-> ##2
      {attenuatorInTransmit, attenuatorInReceive} ==
      {$past(regWdata[1:0], 2) == 2'b01, $past(regWdata[1:0], 2) == 2'b11};
  endproperty
  a_gcf_place: assert property (p_gcf_place)
    else $error("attenuator placement wrong");
  property p_highz;
    regWrite && regAddr == 5'h12 && !bankNow |-> ##2 driverHighZ == $past(regWdata, 2);
  endproperty
  a_highz: assert property (p_highz)
    else $error("driver disable wrong");
  property p_bank;
    regWrite && regAddr == 5'h1f |-> ##2 bankExpanded == ($past(regWdata, 2) == 8'haa);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select wrong");
  property p_event_read;
    regRead && regAddr == 5'h15 && !bankNow |=> regRdata == $past(aisEventFlags);
  endproperty
  a_event_read: assert property (p_event_read)
    else $error("event register read wrong");
  // line controls may only be active on channels that were in loss of signal
  property p_los;
    ((allOnesTransmit | aisInsert) & ~$past(losIn, 3)) == 8'h00;
  endproperty
  a_los: assert property (p_los)
    else $error("all ones or insertion without loss of signal");
  // with recovery off the pin decides; guard skips the two cycles after the setting moves
  property p_rail;
    clockRecoveryOff == $past(clockRecoveryOff, 2) |->
      (singleRail & clockRecoveryOff & ~$past(railSelectPin, 3)) == 8'h00;
  endproperty
  a_rail: assert property (p_rail)
    else $error("single rail forced while recovery off");
endmodule // olcr_regs_properties

// ### verif/olcr_line_model.sv
// line receiver model driving status levels off the clock edge
`timescale 1ns/1ps

module olcr_line_model (
  input wire logic [7:0] losSet,
  input wire logic [7:0] aisSet,
  input wire logic [7:0] railSet,
  output logic [7:0] losIn,
  output logic [7:0] aisIn,
  output logic [7:0] railSelectPin
);
  // =====================================================================
  // levels settle 3 ns late so they never move on a rising edge
  assign #3 losIn = losSet;
  assign #3 aisIn = aisSet;
  assign #3 railSelectPin = railSet;
endmodule // olcr_line_model

// ### verif/olcr_regs_bench.sv
// self-checking testbench of the line interface register bank
`timescale 1ns/1ps

module olcr_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] losSet = 8'h00;
  logic [7:0] aisSet = 8'h00;
  logic [7:0] railSet = 8'h00;
  logic [7:0] regRdata, losIn, aisIn, railSelectPin, allOnesTransmit, aisInsert;
  logic [7:0] driverHighZ, singleRail, clockRecoveryOff, aisEventFlags;
  logic shortProtectEnable, amiSelect, attenuatorDepth64, attenuatorBandwidthHigh;
  logic attenuatorInTransmit, attenuatorInReceive, bankExpanded;
  logic [23:0] templateCode;
  logic [23:0] tmplExp;
  logic [4:0] rstOfs [6] = '{5'h0e, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f};
  logic [7:0] gcfVals [5] = '{8'h01, 8'h52, 8'h03, 8'hbc, 8'h00};
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  // =====================================================================
  // design and line model
  olcr_regs i_olcr_regs (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .losIn(losIn),
    .aisIn(aisIn), .railSelectPin(railSelectPin), .allOnesTransmit(allOnesTransmit),
    .aisInsert(aisInsert), .shortProtectEnable(shortProtectEnable), .amiSelect(amiSelect),
    .attenuatorDepth64(attenuatorDepth64), .attenuatorBandwidthHigh(attenuatorBandwidthHigh),
    .attenuatorInTransmit(attenuatorInTransmit), .attenuatorInReceive(attenuatorInReceive),
    .templateCode(templateCode), .driverHighZ(driverHighZ), .singleRail(singleRail),
    .clockRecoveryOff(clockRecoveryOff), .aisEventFlags(aisEventFlags),
    .bankExpanded(bankExpanded));
  olcr_line_model i_olcr_line_model (.losSet(losSet), .aisSet(aisSet), .railSet(railSet),
    .losIn(losIn), .aisIn(aisIn), .railSelectPin(railSelectPin));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // =====================================================================
  // host port tasks; the idle cycle after each keeps strobes from retriggering
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    @(negedge clk);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    chk(24'(regRdata), 24'(e));
    @(negedge clk);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly 180 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failCount++;
      completeRun();
    end
  end

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    foreach (rstOfs[i]) rdchk(rstOfs[i], 8'h00);
    chk(24'(shortProtectEnable), 24'h1);
    foreach (gcfVals[i])
    begin
      wr(5'h0f, gcfVals[i]);
      chk(24'({shortProtectEnable, amiSelect, attenuatorDepth64, attenuatorBandwidthHigh,
        attenuatorInTransmit, attenuatorInReceive}), 24'({~gcfVals[i][5], gcfVals[i][4:2],
        gcfVals[i][1:0] == 2'b01, gcfVals[i][1:0] == 2'b11}));
      rdchk(5'h0f, gcfVals[i]);
    end
    // reserved index bits set, so only the low three may steer
    for (int i = 0; i < 8; i++)
    begin
      wr(5'h10, 8'hf8 | 8'(i));
      wr(5'h11, 8'h80 | 8'(7 - i));
      tmplExp[3*i +: 3] = 3'(7 - i);
    end
    chk(templateCode, tmplExp);
    for (int i = 0; i < 8; i++)
    begin
      wr(5'h10, 8'(i));
      rdchk(5'h11, 8'h80 | 8'(7 - i));
    end
    wr(5'h12, 8'ha5);
    chk(24'(driverHighZ), 24'ha5);
    wr(5'h13, 8'hff);
    rdchk(5'h13, 8'h00);
    rdchk(5'h1e, 8'h00);
    // loss of signal on four channels, all ones armed on the low nibble
    wr(5'h0e, 8'h0f);
    wr(5'h0f, 8'h40);
    losSet = 8'h33;
    repeat (5) @(negedge clk);
    chk(24'(allOnesTransmit), 24'h03);
    chk(24'(aisInsert), 24'h33);
    rdchk(5'h04, 8'h33);
    wr(5'h0f, 8'h00);
    chk(24'(aisInsert), 24'h00);
    losSet = 8'h00;
    // alarm on all channels, only the low nibble allowed to latch
    wr(5'h14, 8'h0f);
    aisSet = 8'hff;
    repeat (5) @(negedge clk);
    chk(24'(aisEventFlags), 24'h0f);
    rdchk(5'h15, 8'h0f);
    rdchk(5'h13, 8'hff);
    rdchk(5'h15, 8'h00);
    // clearing the alarm is a change too and latches again
    aisSet = 8'h00;
    repeat (5) @(negedge clk);
    rdchk(5'h15, 8'h0f);
    rdchk(5'h13, 8'h00);
    rdchk(5'h15, 8'h00);
    // expanded bank: force single rail, recovery off on the low nibble
    wr(5'h1f, 8'haa);
    chk(24'(bankExpanded), 24'h1);
    wr(5'h00, 8'hff);
    wr(5'h02, 8'h0f);
    repeat (4) @(negedge clk);
    chk(24'(singleRail), 24'hf0);
    railSet = 8'h05;
    repeat (4) @(negedge clk);
    chk(24'(singleRail), 24'hf5);
    chk(24'(clockRecoveryOff), 24'h0f);
    rdchk(5'h02, 8'h0f);
    rdchk(5'h0f, 8'h00);
    rdchk(5'h1f, 8'haa);
    wr(5'h1f, 8'h00);
    rdchk(5'h0e, 8'h0f);
    chk(24'(bankExpanded), 24'h0);
    // a second reset taken from the expanded bank must land in the primary bank
    wr(5'h1f, 8'haa);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(24'(bankExpanded), 24'h0);
    rdchk(5'h1f, 8'h00);
    rdchk(5'h0e, 8'h00);
    completeRun();
  end
endmodule // olcr_regs_bench

bind olcr_regs olcr_regs_properties i_olcr_regs_properties (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
  .regRdata(regRdata), .losIn(losIn), .railSelectPin(railSelectPin),
  .allOnesTransmit(allOnesTransmit), .aisInsert(aisInsert),
  .shortProtectEnable(shortProtectEnable), .amiSelect(amiSelect),
  .attenuatorDepth64(attenuatorDepth64), .attenuatorBandwidthHigh(attenuatorBandwidthHigh),
  .attenuatorInTransmit(attenuatorInTransmit), .attenuatorInReceive(attenuatorInReceive),
  .driverHighZ(driverHighZ), .singleRail(singleRail), .clockRecoveryOff(clockRecoveryOff),
  .aisEventFlags(aisEventFlags), .bankExpanded(bankExpanded));
